// file: rsf_consts.svh
// Constants for the core register set: bit positions, reset values, sizes
`ifndef RSF_CONSTS_SVH
`define RSF_CONSTS_SVH

`define RSF_DATA_W        8
`define RSF_ADDR_W        16
`define RSF_BIT_CARRY     0
`define RSF_BIT_ZERO      1
`define RSF_BIT_NEG       2
`define RSF_BIT_PRIO_LO   3
`define RSF_BIT_HALF      4
`define RSF_BIT_PRIO_HI   5
`define RSF_RSV_MASK      8'hc0
`define RSF_FLAGS_RESET   8'he8
`define RSF_WORK_RESET    8'h00
`define RSF_PTR_RESET     8'h00
`define RSF_FETCH_RESET   16'h0000
`define RSF_STACK_HIGH    8'h01
`define RSF_STACK_LOW_RST 8'hff
`define RSF_IRQ_CTX_BYTES 3'h5
`define RSF_CALL_CTX_BYTES 3'h2

`endif

// file: rsf_pkg.sv
// Types shared by the core register set modules
package rsf_pkg;

    // Register selector for the dedicated-instruction access port
    typedef enum logic [2:0] {
        RSF_SEL_WORK  = 3'b000,
        RSF_SEL_PTR1  = 3'b001,
        RSF_SEL_PTR2  = 3'b010,
        RSF_SEL_PCL   = 3'b011,
        RSF_SEL_PCH   = 3'b100,
        RSF_SEL_SPL   = 3'b101,
        RSF_SEL_FLAGS = 3'b110,
        RSF_SEL_NONE  = 3'b111
    } rsf_sel_t;

    // Software priority encodings held in the two priority bits {hi, lo}
    typedef enum logic [1:0] {
        RSF_LVL0 = 2'b10,
        RSF_LVL1 = 2'b01,
        RSF_LVL2 = 2'b00,
        RSF_LVL3 = 2'b11
    } rsf_level_t;

    // Priority-bit operations
    typedef enum logic [2:0] {
        RSF_PRIO_NONE   = 3'b000,
        RSF_PRIO_UNMASK = 3'b001,
        RSF_PRIO_MASK   = 3'b010,
        RSF_PRIO_ENTRY  = 3'b011,
        RSF_PRIO_HALT   = 3'b100,
        RSF_PRIO_WFI    = 3'b101
    } rsf_prio_op_t;

    // Carry-flag operations
    typedef enum logic [1:0] {
        RSF_CY_NONE  = 2'b00,
        RSF_CY_SET   = 2'b01,
        RSF_CY_CLEAR = 2'b10,
        RSF_CY_ALU   = 2'b11
    } rsf_cy_op_t;

    // ALU result bundle with update enables for sign/zero (shared), half carry and carry
    typedef struct packed {
        logic       upd_nz;
        logic       upd_half;
        rsf_cy_op_t cy_op;
        logic [7:0] result;
        logic       half_carry;
        logic       carry;
    } rsf_alu_t;

    // Register write from a dedicated instruction (load, pop, restore)
    typedef struct packed {
        rsf_sel_t   sel;
        logic [7:0] data;
    } rsf_wr_t;

    // Stack pointer movement
    typedef struct packed {
        logic push;
        logic pop;
        logic reset_stack;
    } rsf_stack_t;

endpackage

// file: rsf_stack_ptr.sv
// Stack pointer with fixed upper byte and silent wrap
`timescale 1ns/1ps

module rsf_stack_ptr (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  ce,
    // Control
    input  wire rsf_pkg::rsf_stack_t   stk,
    input  wire logic                  wr_low,
    input  wire logic [7:0]            wr_data,
    // State
    output logic      [15:0]           sp
);
    import rsf_pkg::*;
    `include "rsf_consts.svh"

    logic [7:0] low_ff;
    logic [7:0] nxt_low;

    always_comb begin
        nxt_low = low_ff;
        if (stk.reset_stack) begin
            nxt_low = `RSF_STACK_LOW_RST; // RULE_15
        end else if (wr_low) begin
            nxt_low = wr_data;
        end else if (stk.push) begin
            // 8-bit arithmetic wraps 00 to ff with no overflow flag
            nxt_low = low_ff - 8'h01; // RULE_16
        end else if (stk.pop) begin
            nxt_low = low_ff + 8'h01; // RULE_16
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_ff <= `RSF_STACK_LOW_RST; // RULE_15
        end else if (ce) begin
            low_ff <= nxt_low;
        end
    end

    // Upper byte is hardwired: the stack spans a single 256-byte page
    assign sp = {`RSF_STACK_HIGH, low_ff}; // RULE_15

endmodule

// file: rsf_core_regs.sv
// Core register set: work, pointer, fetch, stack and flag registers
`timescale 1ns/1ps

// Summary of operation
// RULE_01 - Eight-bit work register holds ALU operands and results; here only a dedicated write loads it, alu.result is never stored.
// RULE_02 - Two eight-bit pointer registers for addressing or temporary data.
// RULE_03 - Second pointer is never touched by interrupt entry or return.
// RULE_04 - Sixteen-bit fetch pointer built from low and high bytes.
// RULE_05 - Registers are reached only through the dedicated access ports.
// RULE_06 - Eight-bit flags register, reset pattern 111x1xxx.
// RULE_07 - Flags can be pushed, popped and each bit tested or set.
// RULE_08 - Half carry follows bit 3 carry on add and add-with-carry.
// RULE_09 - Bit 2 copies result bit 7 of last data operation.
// RULE_10 - Bit 1 set when last data result is zero, else cleared.
// RULE_11 - Carry follows ALU overflow; set and clear ops force it.
// RULE_12 - Priority bits 5,3 encode levels 0 to 3; level 3 masks.
// RULE_13 - Interrupt entry loads priority bits from the level registers.
// RULE_14 - Unmask, mask, return, halt, wait and pop change priority.
// RULE_15 - Stack pointer resets to 01ff; high byte fixed; reset restores ff.
// RULE_16 - Decrement after push, increment before pop, wrap silently.
// RULE_17 - Interrupt pushes five bytes low fetch byte first; call two.
// RULE_18 - Flags not affected by an operation keep their value.
// RULE_19 - Flag bits 7 and 6 read one and ignore writes.
module rsf_core_regs (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  ce,
    // Dedicated register write
    input  wire rsf_pkg::rsf_wr_t      wr,
    // Dedicated register read and context slot read
    input  wire rsf_pkg::rsf_sel_t     rd_sel,
    input  wire logic                  ctx_irq,
    input  wire logic [2:0]            ctx_slot,
    // Fetch pointer control
    input  wire logic                  fetch_load,
    input  wire logic [15:0]           fetch_addr,
    input  wire logic                  fetch_inc,
    // ALU result and flag control
    input  wire rsf_pkg::rsf_alu_t     alu,
    input  wire rsf_pkg::rsf_prio_op_t prio_op,
    input  wire logic [1:0]            entry_level,
    input  wire logic [2:0]            bit_idx,
    input  wire logic                  bit_set,
    input  wire logic                  bit_clr,
    // Stack control
    input  wire rsf_pkg::rsf_stack_t   stk,
    // Register state
    output logic      [7:0]            work_reg,
    output logic      [7:0]            first_pointer_reg,
    output logic      [7:0]            second_pointer_reg,
    output logic      [15:0]           fetch_pointer,
    output logic      [15:0]           stack_top_pointer,
    output logic      [7:0]            flags_reg,
    output logic      [7:0]            rd_data,
    output logic      [7:0]            ctx_byte
);
    import rsf_pkg::*;
    `include "rsf_consts.svh"

    logic [7:0]  work_ff;
    logic [7:0]  ptr1_ff;
    logic [7:0]  ptr2_ff;
    logic [15:0] fetch_ff;
    logic [7:0]  flags_ff;
    logic [7:0]  nxt_flags;
    logic [7:0]  rd_ff;
    logic [7:0]  ctx_ff;
    logic [15:0] sp_w;

    // Byte view of any register; no memory address reaches these
    function automatic logic [7:0] reg_byte(input rsf_sel_t s);
        unique case (s)
            RSF_SEL_WORK:  reg_byte = work_ff;
            RSF_SEL_PTR1:  reg_byte = ptr1_ff;
            RSF_SEL_PTR2:  reg_byte = ptr2_ff;
            RSF_SEL_PCL:   reg_byte = fetch_ff[7:0];
            RSF_SEL_PCH:   reg_byte = fetch_ff[15:8];
            RSF_SEL_SPL:   reg_byte = sp_w[7:0];
            RSF_SEL_FLAGS: reg_byte = flags_ff;
            RSF_SEL_NONE:  reg_byte = 8'h00;
        endcase
    endfunction

    // Context push order, slot 0 pushed first
    function automatic rsf_sel_t ctx_sel(input logic irq, input logic [2:0] slot);
        ctx_sel = RSF_SEL_NONE;
        if (irq && slot < `RSF_IRQ_CTX_BYTES) begin
            unique case (slot)
                3'h0:    ctx_sel = RSF_SEL_PCL; // RULE_17
                3'h1:    ctx_sel = RSF_SEL_PCH;
                3'h2:    ctx_sel = RSF_SEL_PTR1;
                3'h3:    ctx_sel = RSF_SEL_WORK;
                default: ctx_sel = RSF_SEL_FLAGS;
            endcase
        end else if (!irq && slot < `RSF_CALL_CTX_BYTES) begin
            ctx_sel = slot[0] ? RSF_SEL_PCH : RSF_SEL_PCL; // RULE_17
        end
    endfunction

    rsf_stack_ptr u_stack (
        .clk     (clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .stk     (stk),
        .wr_low  (wr.sel == RSF_SEL_SPL),
        .wr_data (wr.data),
        .sp      (sp_w)
    );

    // Work register: loaded only by a dedicated write; the ALU result is never stored here
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            work_ff <= `RSF_WORK_RESET;
        end else if (ce) begin
            if (wr.sel == RSF_SEL_WORK) begin
                work_ff <= wr.data; // RULE_01
            end
        end
    end

    // Pointer registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr1_ff <= `RSF_PTR_RESET;
            ptr2_ff <= `RSF_PTR_RESET;
        end else if (ce) begin
            if (wr.sel == RSF_SEL_PTR1) begin
                ptr1_ff <= wr.data; // RULE_02
            end
            // Not in the context set, so entry and return never select it
            if (wr.sel == RSF_SEL_PTR2) begin
                ptr2_ff <= wr.data; // RULE_03
            end
        end
    end

    // Fetch pointer: byte restore, full load, or step
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fetch_ff <= `RSF_FETCH_RESET;
        end else if (ce) begin
            if (fetch_load) begin
                fetch_ff <= fetch_addr; // RULE_04
            end else if (wr.sel == RSF_SEL_PCL) begin
                fetch_ff[7:0] <= wr.data; // RULE_04
            end else if (wr.sel == RSF_SEL_PCH) begin
                fetch_ff[15:8] <= wr.data; // RULE_04
            end else if (fetch_inc) begin
                fetch_ff <= fetch_ff + 16'h0001;
            end
        end
    end

    // Flags: pop first, then ALU, bit ops and priority ops override per bit
    always_comb begin
        nxt_flags = flags_ff; // RULE_18
        if (wr.sel == RSF_SEL_FLAGS) begin
            nxt_flags = wr.data; // RULE_07
        end
        if (alu.upd_half) begin
            nxt_flags[`RSF_BIT_HALF] = alu.half_carry; // RULE_08
        end
        if (alu.upd_nz) begin
            nxt_flags[`RSF_BIT_NEG]  = alu.result[7]; // RULE_09
            nxt_flags[`RSF_BIT_ZERO] = (alu.result == 8'h00); // RULE_10
        end
        unique case (alu.cy_op)
            RSF_CY_NONE:  nxt_flags[`RSF_BIT_CARRY] = nxt_flags[`RSF_BIT_CARRY];
            RSF_CY_SET:   nxt_flags[`RSF_BIT_CARRY] = 1'b1; // RULE_11
            RSF_CY_CLEAR: nxt_flags[`RSF_BIT_CARRY] = 1'b0; // RULE_11
            RSF_CY_ALU:   nxt_flags[`RSF_BIT_CARRY] = alu.carry; // RULE_11
        endcase
        if (bit_set) begin
            nxt_flags[bit_idx] = 1'b1; // RULE_07
        end else if (bit_clr) begin
            nxt_flags[bit_idx] = 1'b0; // RULE_07
        end
        // Return restores the bits via the flags pop, so it needs no case here
        unique case (prio_op)
            RSF_PRIO_NONE: begin
            end
            RSF_PRIO_UNMASK, RSF_PRIO_HALT, RSF_PRIO_WFI: begin
                {nxt_flags[`RSF_BIT_PRIO_HI], nxt_flags[`RSF_BIT_PRIO_LO]} = RSF_LVL0; // RULE_14
            end
            RSF_PRIO_MASK: begin
                {nxt_flags[`RSF_BIT_PRIO_HI], nxt_flags[`RSF_BIT_PRIO_LO]} = RSF_LVL3; // RULE_12
            end
            RSF_PRIO_ENTRY: begin
                nxt_flags[`RSF_BIT_PRIO_HI] = entry_level[1]; // RULE_13
                nxt_flags[`RSF_BIT_PRIO_LO] = entry_level[0]; // RULE_13
            end
            default: begin
            end
        endcase
        nxt_flags = nxt_flags | `RSF_RSV_MASK; // RULE_19
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_ff <= `RSF_FLAGS_RESET; // RULE_06
        end else if (ce) begin
            flags_ff <= nxt_flags;
        end
    end

    // Read ports registered so every output comes from a flip-flop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_ff  <= 8'h00;
            ctx_ff <= 8'h00;
        end else if (ce) begin
            rd_ff  <= reg_byte(rd_sel); // RULE_05
            ctx_ff <= reg_byte(ctx_sel(ctx_irq, ctx_slot)); // RULE_17
        end
    end

    assign work_reg           = work_ff;
    assign first_pointer_reg  = ptr1_ff;
    assign second_pointer_reg = ptr2_ff;
    assign fetch_pointer      = fetch_ff;
    assign stack_top_pointer  = sp_w;
    assign flags_reg          = flags_ff;
    assign rd_data            = rd_ff;
    assign ctx_byte           = ctx_ff;

endmodule

// file: rsf_alu_model.sv
// Behavioural execution datapath that feeds results into the register set
`timescale 1ns/1ps
module rsf_alu_model (
    // Operation: 0 none, 1 add, 2 and
    input  wire logic [1:0]         op,
    input  wire logic [7:0]         a,
    input  wire logic [7:0]         b,
    input  wire rsf_pkg::rsf_cy_op_t cy_cmd,
    // Result bundle
    output rsf_pkg::rsf_alu_t       alu
);
    import rsf_pkg::*;
    logic [8:0] sum;
    logic [4:0] nib;
    always_comb begin
        sum            = {1'b0, a} + {1'b0, b};
        nib            = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        alu.upd_nz     = (op != 2'h0);
        alu.upd_half   = (op == 2'h1);
        alu.cy_op      = (op == 2'h1) ? RSF_CY_ALU : cy_cmd;
        alu.result     = (op == 2'h2) ? (a & b) : sum[7:0];
        alu.half_carry = nib[4];
        alu.carry      = sum[8];
    end
endmodule

// file: rsf_core_regs_sva.sv
// Port-level assertions for the core register set
`timescale 1ns/1ps
module rsf_core_regs_sva (
    // Clock and reset
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire logic                  ce,
    // Requests
    input wire rsf_pkg::rsf_wr_t      wr,
    input wire rsf_pkg::rsf_sel_t     rd_sel,
    input wire logic                  ctx_irq,
    input wire logic [2:0]            ctx_slot,
    input wire rsf_pkg::rsf_alu_t     alu,
    input wire rsf_pkg::rsf_prio_op_t prio_op,
    input wire logic [1:0]            entry_level,
    input wire logic                  bit_set,
    input wire logic                  bit_clr,
    input wire rsf_pkg::rsf_stack_t   stk,
    // State
    input wire logic [7:0]            work_reg,
    input wire logic [7:0]            second_pointer_reg,
    input wire logic [15:0]           fetch_pointer,
    input wire logic [15:0]           stack_top_pointer,
    input wire logic [7:0]            flags_reg,
    input wire logic [7:0]            rd_data,
    input wire logic [7:0]            ctx_byte
);
    import rsf_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // No competing flag writer in this cycle
    logic quiet;
    assign quiet = !bit_set && !bit_clr && wr.sel != RSF_SEL_FLAGS;
    sequence s_push;
        ce && stk.push && !stk.pop && !stk.reset_stack && wr.sel != RSF_SEL_SPL;
    endsequence
    sequence s_slot0;
        ce && ctx_irq && ctx_slot == 3'h0;
    endsequence
    a_fixed_bits: assert property (
        flags_reg[7:6] == 2'b11 && stack_top_pointer[15:8] == 8'h01)
        else $error("fixed bits wrong");
    a_push_dec: assert property (
        s_push |=> stack_top_pointer[7:0] == $past(stack_top_pointer[7:0]) - 8'h01)
        else $error("push did not decrement");
    a_work_load: assert property (
        ce && wr.sel == RSF_SEL_WORK |=> work_reg == $past(wr.data))
        else $error("work load wrong");
    a_ptr2_keep: assert property (
        ce && wr.sel != RSF_SEL_PTR2 |=> $stable(second_pointer_reg))
        else $error("second pointer moved");
    a_nz_flags: assert property (
        ce && alu.upd_nz && quiet |=> flags_reg[2] == $past(alu.result[7])
            && flags_reg[1] == ($past(alu.result) == 8'h00))
        else $error("sign or zero flag wrong");
    a_half_carry: assert property (
        ce && alu.upd_half && quiet |=> flags_reg[4] == $past(alu.half_carry))
        else $error("half carry wrong");
    a_carry_set: assert property (
        ce && alu.cy_op == RSF_CY_SET && quiet |=> flags_reg[0])
        else $error("carry not set");
    a_prio_entry: assert property (
        ce && prio_op == RSF_PRIO_ENTRY |=> {flags_reg[5], flags_reg[3]} == $past(entry_level))
        else $error("entry level wrong");
    a_prio_mask: assert property (
        ce && prio_op == RSF_PRIO_MASK |=> {flags_reg[5], flags_reg[3]} == 2'b11)
        else $error("mask level wrong");
    a_flags_hold: assert property (
        ce && quiet && !alu.upd_nz && !alu.upd_half && alu.cy_op == RSF_CY_NONE
            && prio_op == RSF_PRIO_NONE |=> $stable(flags_reg))
        else $error("flags changed");
    a_irq_ctx: assert property (
        s_slot0 |=> ctx_byte == $past(fetch_pointer[7:0]))
        else $error("context slot wrong");
    a_rd_flags: assert property (
        ce && rd_sel == RSF_SEL_FLAGS |=> rd_data == $past(flags_reg))
        else $error("flags read wrong");
endmodule
bind rsf_core_regs rsf_core_regs_sva u_sva (.clk(clk), .rst_n(rst_n), .ce(ce), .wr(wr),
    .rd_sel(rd_sel), .ctx_irq(ctx_irq), .ctx_slot(ctx_slot), .alu(alu), .prio_op(prio_op),
    .entry_level(entry_level), .bit_set(bit_set), .bit_clr(bit_clr), .stk(stk),
    .work_reg(work_reg), .second_pointer_reg(second_pointer_reg), .fetch_pointer(fetch_pointer),
    .stack_top_pointer(stack_top_pointer), .flags_reg(flags_reg), .rd_data(rd_data),
    .ctx_byte(ctx_byte));

// file: test_rsf_core_regs.sv
// Self-checking testbench for the core register set
`timescale 1ns/1ps
module test_rsf_core_regs;
    import rsf_pkg::*;
    logic         clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         ce = 1'b1;
    rsf_wr_t      wr;
    rsf_sel_t     rd_sel;
    logic         ctx_irq, fetch_load, fetch_inc, bit_set, bit_clr;
    logic [2:0]   ctx_slot, bit_idx;
    logic [15:0]  fetch_addr, fetch_pointer, stack_top_pointer;
    logic [1:0]   op, entry_level;
    logic [7:0]   a, b, work_reg, ptr1, ptr2, flags_reg, rd_data, ctx_byte;
    rsf_cy_op_t   cy_cmd;
    rsf_alu_t     alu;
    rsf_prio_op_t prio_op;
    rsf_stack_t   stk;
    int           n_mismatch = 0;
    int           n_compared = 0;
    rsf_alu_model u_alu (.op(op), .a(a), .b(b), .cy_cmd(cy_cmd), .alu(alu));
    rsf_core_regs dut (.clk(clk), .rst_n(rst_n), .ce(ce), .wr(wr), .rd_sel(rd_sel),
        .ctx_irq(ctx_irq), .ctx_slot(ctx_slot), .fetch_load(fetch_load), .fetch_addr(fetch_addr),
        .fetch_inc(fetch_inc), .alu(alu), .prio_op(prio_op), .entry_level(entry_level),
        .bit_idx(bit_idx), .bit_set(bit_set), .bit_clr(bit_clr), .stk(stk), .work_reg(work_reg),
        .first_pointer_reg(ptr1), .second_pointer_reg(ptr2), .fetch_pointer(fetch_pointer),
        .stack_top_pointer(stack_top_pointer), .flags_reg(flags_reg), .rd_data(rd_data),
        .ctx_byte(ctx_byte));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic idle();
        wr = '{RSF_SEL_NONE, 8'h00};
        rd_sel = RSF_SEL_NONE;
        {ctx_irq, fetch_load, fetch_inc, bit_set, bit_clr} = 5'h00;
        {ctx_slot, bit_idx, op, entry_level, a, b} = 26'h0;
        fetch_addr = 16'h0000;
        cy_cmd = RSF_CY_NONE;
        prio_op = RSF_PRIO_NONE;
        stk = 3'b000;
    endtask
    // Inputs change at the falling edge, results are read one falling edge later
    task automatic tick();
        @(posedge clk);
        @(negedge clk);
        idle();
    endtask
    task automatic chk8(string what, logic [7:0] exp, logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk16(string what, logic [15:0] exp, logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic t_reset();
        chk8("work_reg", 8'h00, work_reg);
        chk8("second_pointer_reg", 8'h00, ptr2);
        chk8("flags_reg", 8'he8, flags_reg);
        chk16("stack_top_pointer", 16'h01ff, stack_top_pointer);
        $display("test reset done");
    endtask
    task automatic t_regs();
        logic [7:0] d = 8'h00;
        for (int i = 0; i < 6; i++) begin
            d = d + 8'h11;
            wr = '{rsf_sel_t'(i), d};
            tick();
            rd_sel = rsf_sel_t'(i);
            tick();
            chk8("rd_data", d, rd_data);
        end
        chk16("fetch_pointer", 16'h5544, fetch_pointer);
        chk8("first_pointer_reg", 8'h22, ptr1);
        chk16("stack_top_pointer", 16'h0166, stack_top_pointer);
        fetch_inc = 1'b1;
        tick();
        chk16("fetch_pointer", 16'h5545, fetch_pointer);
        $display("test regs done");
    endtask
    task automatic fstep(logic [1:0] o, logic [7:0] x, logic [7:0] y, rsf_cy_op_t c,
                         logic [7:0] e);
        op = o;
        a = x;
        b = y;
        cy_cmd = c;
        tick();
        chk8("flags_reg", e, flags_reg);
    endtask
    task automatic t_flags();
        wr = '{RSF_SEL_FLAGS, 8'h00};
        tick();
        chk8("flags_reg", 8'hc0, flags_reg);
        fstep(2'h1, 8'h0f, 8'h01, RSF_CY_NONE, 8'hd0);
        fstep(2'h1, 8'hff, 8'h01, RSF_CY_NONE, 8'hd3);
        fstep(2'h2, 8'h80, 8'hff, RSF_CY_NONE, 8'hd5);
        fstep(2'h0, 8'h00, 8'h00, RSF_CY_CLEAR, 8'hd4);
        fstep(2'h0, 8'h00, 8'h00, RSF_CY_SET, 8'hd5);
        bit_idx = 3'h3;
        bit_set = 1'b1;
        tick();
        chk8("flags_reg", 8'hdd, flags_reg);
        bit_idx = 3'h4;
        bit_clr = 1'b1;
        tick();
        chk8("flags_reg", 8'hcd, flags_reg);
        bit_idx = 3'h6;
        bit_clr = 1'b1;
        rd_sel = RSF_SEL_FLAGS;
        tick();
        chk8("flags_reg", 8'hcd, flags_reg);
        chk8("rd_data", 8'hcd, rd_data);
        $display("test flags done");
    endtask
    task automatic t_prio();
        rsf_prio_op_t po [7] = '{RSF_PRIO_MASK, RSF_PRIO_UNMASK, RSF_PRIO_ENTRY, RSF_PRIO_HALT,
                                 RSF_PRIO_ENTRY, RSF_PRIO_WFI, RSF_PRIO_ENTRY};
        logic [1:0]   lv [7] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h3, 2'h0, 2'h0};
        logic [7:0]   ex [7] = '{8'hed, 8'he5, 8'hcd, 8'he5, 8'hed, 8'he5, 8'hc5};
        for (int i = 0; i < 7; i++) begin
            prio_op = po[i];
            entry_level = lv[i];
            tick();
            chk8("flags_reg", ex[i], flags_reg);
        end
        chk8("second_pointer_reg", 8'h33, ptr2);
        $display("test prio done");
    endtask
    task automatic t_stack();
        logic [2:0] st [5] = '{3'b001, 3'b100, 3'b010, 3'b010, 3'b100};
        logic [7:0] lo [5] = '{8'hff, 8'hfe, 8'hff, 8'h00, 8'hff};
        for (int i = 0; i < 5; i++) begin
            stk = st[i];
            tick();
            chk16("stack_top_pointer", {8'h01, lo[i]}, stack_top_pointer);
        end
        $display("test stack done");
    endtask
    task automatic t_ctx();
        logic [7:0] ex [9] = '{8'h34, 8'h12, 8'h22, 8'h11, 8'hc5, 8'h00, 8'h34, 8'h12, 8'h00};
        fetch_load = 1'b1;
        fetch_addr = 16'h1234;
        fetch_inc = 1'b1;
        tick();
        chk16("fetch_pointer", 16'h1234, fetch_pointer);
        for (int i = 0; i < 9; i++) begin
            ctx_irq = (i < 6);
            ctx_slot = 3'((i < 6) ? i : i - 6);
            tick();
            chk8("ctx_byte", ex[i], ctx_byte);
        end
        ce = 1'b0;
        wr = '{RSF_SEL_WORK, 8'h99};
        stk = 3'b100;
        tick();
        ce = 1'b1;
        chk8("work_reg", 8'h11, work_reg);
        chk16("stack_top_pointer", 16'h01ff, stack_top_pointer);
        $display("test context done");
    endtask
    task automatic wrap_up();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        #1000000;
        n_mismatch++;
        wrap_up();
    end
    initial begin
        idle();
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        t_regs();
        t_flags();
        t_prio();
        t_stack();
        t_ctx();
        rst_n = 1'b0;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        wrap_up();
    end
endmodule
